// ### hdl/fpu_nan_wait_control.sv
// nan propagation, exception gating and control-state unit
`timescale 1ns/1ps
`include "fpu_nan_wait_defines.svh"
module fpu_nan_wait_control (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // instruction issue
   input wire logic op_valid,
   input wire fpu_nan_wait_pkg::op_e op_code,
   input wire logic op_no_wait,
   input wire logic [2:0] op_reg,
   input wire logic store_to_gpr,
   // operands and arithmetic core
   input wire logic [79:0] src_a,
   input wire logic [79:0] src_b,
   input wire logic src_b_used,
   input wire logic [79:0] core_result,
   input wire logic [5:0] core_exc,
   // memory image for loads
   input wire logic [15:0] mem_cw,
   input wire logic [15:0] mem_sw,
   input wire logic [15:0] mem_tag,
   // answers
   output logic done,
   output logic trap,
   output logic dest_we,
   output logic [79:0] dest_data,
   output logic mem_we,
   output logic gpr_we,
   output logic [15:0] store_word,
   output logic save_env,
   output logic save_regs,
   output logic load_regs,
   output logic [15:0] cw_out,
   output logic [15:0] sw_out,
   output logic [15:0] tag_out,
   output logic exception_summary_flag
);
   logic [15:0] cw_q, cw_d;
   logic [15:0] sw_q, sw_d;
   logic [15:0] tag_q, tag_d;
   logic done_q, trap_q, dest_we_q, mem_we_q, gpr_we_q;
   logic save_env_q, save_regs_q, load_regs_q;
   logic [79:0] dest_q;
   logic [15:0] store_q;

   function automatic fpu_nan_wait_pkg::nan_kind_e classify(input logic [79:0] v);
      // sign ignored; zero fraction with max exponent is infinity
      if (v[78:64] != `EXP_ALL_ONES || v[`FRAC_MSB:0] == 63'h0) begin
         classify = fpu_nan_wait_pkg::nan_none;
      end else if (v[`FRAC_MSB]) begin
         classify = fpu_nan_wait_pkg::nan_quiet;
      end else begin
         classify = fpu_nan_wait_pkg::nan_signalling;
      end
   endfunction : classify

   function automatic logic [79:0] quieten(input logic [79:0] v);
      quieten = v;
      quieten[`FRAC_MSB] = 1'b1;
   endfunction : quieten

   fpu_nan_wait_pkg::nan_kind_e kind_a, kind_b;
   wire is_arith = op_code inside {fpu_nan_wait_pkg::log2_multiply_op,
      fpu_nan_wait_pkg::log2_plus_one_multiply_op, fpu_nan_wait_pkg::exp2_minus_one_op,
      fpu_nan_wait_pkg::power_of_two_multiply_op, fpu_nan_wait_pkg::arith_op};
   wire is_legacy = op_code inside {fpu_nan_wait_pkg::legacy_opcode_a,
      fpu_nan_wait_pkg::legacy_opcode_b, fpu_nan_wait_pkg::legacy_opcode_c};
   assign kind_a = classify(src_a);
   assign kind_b = src_b_used ? classify(src_b) : fpu_nan_wait_pkg::nan_none;
   wire snan_in = kind_a == fpu_nan_wait_pkg::nan_signalling ||
      kind_b == fpu_nan_wait_pkg::nan_signalling;
   wire any_nan = kind_a != fpu_nan_wait_pkg::nan_none || kind_b != fpu_nan_wait_pkg::nan_none;
   wire a_larger = src_a[63:0] >= src_b[63:0];
   // nan result selection
   wire [79:0] nan_pick =
      (kind_b == fpu_nan_wait_pkg::nan_none) ? quieten(src_a) :
      (kind_a == fpu_nan_wait_pkg::nan_none) ? quieten(src_b) :
      (kind_a == fpu_nan_wait_pkg::nan_quiet && kind_b == fpu_nan_wait_pkg::nan_signalling)
         ? src_a :
      (kind_b == fpu_nan_wait_pkg::nan_quiet && kind_a == fpu_nan_wait_pkg::nan_signalling)
         ? src_b :
      (a_larger ? quieten(src_a) : quieten(src_b));
   // invalid raised by signalling nan or by the core itself
   wire [5:0] exc_raw = snan_in ? (core_exc | 6'h01) : (any_nan ? 6'h00 : core_exc);
   wire invalid_unmasked = exc_raw[`SW_IE] && !cw_q[`SW_IE];
   wire [79:0] arith_out = any_nan ? nan_pick :
      (exc_raw[`SW_IE] ? `INDEFINITE : core_result);
   // pending = sticky flags not masked
   wire pending = |(sw_q[`EXC_BITS-1:0] & ~cw_q[`EXC_BITS-1:0]);
   wire waits = op_valid && !op_no_wait && !is_legacy;
   wire take_trap = waits && pending;
   wire exec = op_valid && !take_trap;
   wire [2:0] top = sw_q[`SW_TOP_LSB+2:`SW_TOP_LSB];
   wire [2:0] rel_reg = 3'(top + op_reg);
   wire [5:0] new_flags = sw_q[`EXC_BITS-1:0] | exc_raw;
   wire [2:0] top_up = 3'(top + 3'h1);
   wire [2:0] top_down = 3'(top - 3'h1);
   // one decoded strobe per control form except idle and sync check, all qualified by exec
   wire do_init = exec && op_code == fpu_nan_wait_pkg::unit_initialise_op;
   wire do_cw_load = exec && op_code == fpu_nan_wait_pkg::control_word_load_op;
   wire do_env_load = exec && op_code == fpu_nan_wait_pkg::environment_load_op;
   wire do_restore = exec && op_code == fpu_nan_wait_pkg::full_state_restore_op;
   wire do_clear = exec && op_code == fpu_nan_wait_pkg::exception_flag_clear_op;
   wire do_inc = exec && op_code == fpu_nan_wait_pkg::stack_pointer_increment_op;
   wire do_dec = exec && op_code == fpu_nan_wait_pkg::stack_pointer_decrement_op;
   wire do_release = exec && op_code == fpu_nan_wait_pkg::register_release_op;
   wire do_arith = exec && is_arith;
   wire do_cw_store = exec && op_code == fpu_nan_wait_pkg::control_word_store_op;
   wire do_sw_store = exec && op_code == fpu_nan_wait_pkg::status_word_store_op;
   wire do_env_save = exec && op_code == fpu_nan_wait_pkg::environment_save_op;
   wire do_state_save = exec && op_code == fpu_nan_wait_pkg::full_state_save_op;
   wire load_env = do_env_load || do_restore;
   // next values of the one-cycle answer pulses
   wire dest_we_d = do_arith && !invalid_unmasked;
   wire mem_we_d = do_cw_store || (do_sw_store && !store_to_gpr);
   wire gpr_we_d = do_sw_store && store_to_gpr;
   wire save_env_d = do_env_save || do_state_save;
   wire [15:0] store_d = (op_code == fpu_nan_wait_pkg::control_word_store_op) ? cw_q : sw_q;

   // core computes log, exp and scale, this unit routes it
   always_comb begin
      cw_d = cw_q;
      if (do_init) begin
         cw_d = `CW_RESET;
      end else if (do_cw_load || load_env) begin
         cw_d = mem_cw;
      end
   end

   always_comb begin
      sw_d = sw_q;
      if (do_init) begin
         sw_d = `SW_RESET;
      end else if (load_env) begin
         sw_d = mem_sw;
      end else if (do_clear) begin
         sw_d[`EXC_BITS-1:0] = 6'h00;
         sw_d[`SW_ES] = 1'b0;
      end else if (do_inc) begin
         sw_d[`SW_TOP_LSB+2:`SW_TOP_LSB] = top_up;
      end else if (do_dec) begin
         sw_d[`SW_TOP_LSB+2:`SW_TOP_LSB] = top_down;
      end else if (do_arith) begin
         sw_d[`EXC_BITS-1:0] = new_flags;
         sw_d[`SW_ES] = |(new_flags & ~cw_q[`EXC_BITS-1:0]);
      end
   end

   always_comb begin
      tag_d = tag_q;
      if (do_init) begin
         tag_d = `TAG_RESET;
      end else if (load_env) begin
         tag_d = mem_tag;
      end else if (do_release) begin
         tag_d[{rel_reg, 1'b0} +: 2] = `TAG_EMPTY;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cw_q <= `CW_RESET;
      end else begin
         cw_q <= cw_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sw_q <= `SW_RESET;
      end else begin
         sw_q <= sw_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tag_q <= `TAG_RESET;
      end else begin
         tag_q <= tag_d;
      end
   end

   // legacy forms still report done, with no state touched
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= exec;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         trap_q <= 1'b0;
      end else begin
         trap_q <= take_trap;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dest_we_q <= 1'b0;
      end else begin
         dest_we_q <= dest_we_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dest_q <= 80'h0;
      end else begin
         dest_q <= arith_out;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_we_q <= 1'b0;
      end else begin
         mem_we_q <= mem_we_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gpr_we_q <= 1'b0;
      end else begin
         gpr_we_q <= gpr_we_d;
      end
   end

   // stores sample state before any update in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         store_q <= 16'h0;
      end else begin
         store_q <= store_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         save_env_q <= 1'b0;
      end else begin
         save_env_q <= save_env_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         save_regs_q <= 1'b0;
      end else begin
         save_regs_q <= do_state_save;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         load_regs_q <= 1'b0;
      end else begin
         load_regs_q <= do_restore;
      end
   end

   assign done = done_q;
   assign trap = trap_q;
   assign dest_we = dest_we_q;
   assign dest_data = dest_q;
   assign mem_we = mem_we_q;
   assign gpr_we = gpr_we_q;
   assign store_word = store_q;
   assign save_env = save_env_q;
   assign save_regs = save_regs_q;
   assign load_regs = load_regs_q;
   assign cw_out = cw_q;
   assign sw_out = sw_q;
   assign tag_out = tag_q;
   assign exception_summary_flag = sw_q[`SW_ES];
endmodule : fpu_nan_wait_control

// ### hdl/fpu_nan_wait_defines.svh
// constants for the nan and wait-control unit
// Behaviour
// - log2 multiply returns y times log2 x
// - plus-one log returns y times log2(x+1)
// - exp2 minus one, defined for -1..+1
// - scale multiplies by integral power of two
// - transcendental error below 1 / 1.5 ulp
// - transcendental results monotonic in inputs
// - initialise returns all registers to defaults
// - control load, control/status store, status to gpr
// - environment and full state save and restore
// - sync check handles pending unmasked exceptions first
// - waiting instructions check exceptions before operating
// - non-waiting forms ignore pending exceptions
// - stack pointer step, register free, idle, clear
// - legacy opcodes do nothing at all; the unit still pulses done for them
// - classify nan by top fraction bit
// - quiet nans propagate, signalling raise invalid
// - masked invalid quietens nan, writes, sets flag
// - unmasked invalid faults, destination not written
// - two-nan selection by kind and significand
// - nan with real returns quietened nan
// - invalid without nan gives real indefinite
// - sticky flag and mask per exception, summary
// - pending unmasked exception traps next waiting op
`ifndef FPU_NAN_WAIT_DEFINES_SVH
`define FPU_NAN_WAIT_DEFINES_SVH
`define CW_RESET 16'h037F
`define SW_RESET 16'h0000
`define TAG_RESET 16'hFFFF
`define SW_IE 0
`define SW_ES 7
`define SW_TOP_LSB 11
`define EXC_BITS 6
`define FRAC_MSB 62
`define EXP_ALL_ONES 15'h7FFF
`define INDEFINITE 80'hFFFF_C000_0000_0000_0000
`define TAG_EMPTY 2'h3
`define TAG_VALID 2'h0
`define REG_COUNT 8
`endif

// ### hdl/fpu_nan_wait_pkg.sv
// types for the nan and wait-control unit
package fpu_nan_wait_pkg;
   typedef enum logic [4:0] {
      op_none = 5'h00,
      log2_multiply_op = 5'h01,
      log2_plus_one_multiply_op = 5'h02,
      exp2_minus_one_op = 5'h03,
      power_of_two_multiply_op = 5'h04,
      arith_op = 5'h05,
      unit_initialise_op = 5'h06,
      control_word_load_op = 5'h07,
      control_word_store_op = 5'h08,
      status_word_store_op = 5'h09,
      exception_flag_clear_op = 5'h0A,
      environment_load_op = 5'h0B,
      environment_save_op = 5'h0C,
      full_state_restore_op = 5'h0D,
      full_state_save_op = 5'h0E,
      stack_pointer_increment_op = 5'h0F,
      stack_pointer_decrement_op = 5'h10,
      register_release_op = 5'h11,
      fp_idle_op = 5'h12,
      sync_check_op = 5'h13,
      legacy_opcode_a = 5'h14,
      legacy_opcode_b = 5'h15,
      legacy_opcode_c = 5'h16
   } op_e;
   typedef enum logic [1:0] {
      nan_none = 2'h0,
      nan_quiet = 2'h1,
      nan_signalling = 2'h3
   } nan_kind_e;
endpackage : fpu_nan_wait_pkg

// ### verif/fpu_core_model.sv
// arithmetic core stand-in: echoes operand a, flags invalid on request
`timescale 1ns/1ps
module fpu_core_model (
   // operands
   input wire logic [79:0] src_a,
   input wire logic inv_req,
   // result
   output logic [79:0] core_result,
   output logic [5:0] core_exc
);
   assign core_result = src_a;
   assign core_exc = {5'h00, inv_req};
endmodule : fpu_core_model

// ### verif/fpu_nan_wait_control_assertions.sv
// port-level checks for the nan and wait-control unit
`timescale 1ns/1ps
module fpu_nan_wait_control_assertions (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // issue
   input wire logic op_valid,
   input wire fpu_nan_wait_pkg::op_e op_code,
   input wire logic op_no_wait,
   input wire logic [5:0] core_exc,
   // answers
   input wire logic done,
   input wire logic trap,
   input wire logic dest_we,
   input wire logic [15:0] cw_out,
   input wire logic [15:0] sw_out,
   input wire logic [15:0] tag_out,
   input wire logic exception_summary_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire logic pend = |(sw_out[5:0] & ~cw_out[5:0]);
   // legacy codes sit at the top of the opcode space
   wire logic legacy = (op_code >= fpu_nan_wait_pkg::legacy_opcode_a);
   wire logic blocked = op_valid && !op_no_wait && !legacy && pend;
   wire logic arith = op_valid && op_code == fpu_nan_wait_pkg::arith_op && !pend && core_exc[0];
   sequence s_blocked; blocked; endsequence
   sequence s_held; trap && !done && !dest_we; endsequence
   chk_trap_waiting: assert property (s_blocked |=> s_held)
      else $error("waiting op not trapped");
   chk_trap_frozen: assert property (s_blocked |=> $stable(cw_out) && $stable(sw_out))
      else $error("state moved on trap");
   chk_no_wait_runs: assert property (op_valid && op_no_wait |=> done && !trap)
      else $error("non-waiting op refused");
   chk_legacy_idle: assert property (op_valid && legacy |=> done && $stable(tag_out)
      && $stable(cw_out) && $stable(sw_out))
      else $error("legacy opcode changed state");
   chk_init_words: assert property (op_valid && op_code == fpu_nan_wait_pkg::unit_initialise_op
      && !blocked |=> cw_out == 16'h037F && sw_out == 16'h0000 && tag_out == 16'hFFFF)
      else $error("initialise left wrong words");
   chk_clear_flags: assert property (op_valid && !blocked
      && op_code == fpu_nan_wait_pkg::exception_flag_clear_op
      |=> sw_out[5:0] == 6'h00 && !exception_summary_flag)
      else $error("flags not cleared");
   chk_summary_bit: assert property (exception_summary_flag == sw_out[7])
      else $error("summary flag differs from status");
   chk_unmasked_skip: assert property (arith && !cw_out[0] |=> !dest_we && sw_out[0])
      else $error("unmasked invalid wrote result");
   chk_masked_write: assert property (arith && cw_out[0] |=> dest_we && sw_out[0])
      else $error("masked invalid gave no result");
endmodule : fpu_nan_wait_control_assertions
bind fpu_nan_wait_control fpu_nan_wait_control_assertions u_chk (.*);

// ### verif/fpu_nan_wait_control_tb.sv
// self-checking bench for the nan and wait-control unit
`timescale 1ns/1ps
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module fpu_nan_wait_control_tb;
   logic mclk, sys_rst, op_valid, op_no_wait, store_to_gpr, src_b_used, inv_req;
   fpu_nan_wait_pkg::op_e op_code;
   logic [2:0] op_reg;
   logic [79:0] src_a, src_b, core_result, dest_data;
   logic [5:0] core_exc;
   logic [15:0] mem_cw, mem_sw, mem_tag, store_word, cw_out, sw_out, tag_out;
   logic done, trap, dest_we, mem_we, gpr_we, save_env, save_regs, load_regs, es;
   int fail_count = 0;
   int compares = 0;
   localparam logic [79:0] SN = 80'h7FFF_8000_0000_0000_1234, SQ = 80'h7FFF_C000_0000_0000_1234,
      SN2 = 80'h7FFF_8000_0000_0000_5678, SQ2 = 80'h7FFF_C000_0000_0000_5678,
      QN = 80'h7FFF_C000_0000_0000_0055, QN2 = 80'hFFFF_C000_0000_0000_0099,
      RL = 80'h3FFF_8000_0000_0000_0000, INF = 80'h7FFF_8000_0000_0000_0000;
   fpu_nan_wait_control u_dut (.mclk, .sys_rst, .op_valid, .op_code, .op_no_wait, .op_reg,
      .store_to_gpr, .src_a, .src_b, .src_b_used, .core_result, .core_exc, .mem_cw, .mem_sw,
      .mem_tag, .done, .trap, .dest_we, .dest_data, .mem_we, .gpr_we, .store_word, .save_env,
      .save_regs, .load_regs, .cw_out, .sw_out, .tag_out, .exception_summary_flag(es));
   fpu_core_model u_core (.src_a, .inv_req, .core_result, .core_exc);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic give_verdict;
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   // a gap cycle between ops keeps op_valid to one assignment per step
   task automatic op(input fpu_nan_wait_pkg::op_e c, input logic nw);
      @(negedge mclk);
      op_code = c;
      op_no_wait = nw;
      op_valid = 1'b1;
      @(negedge mclk);
      op_valid = 1'b0;
   endtask : op
   task automatic nan(input logic [79:0] a, input logic [79:0] b, input logic [79:0] r,
      input logic inv);
      src_a = a;
      src_b = b;
      inv_req = inv;
      op(fpu_nan_wait_pkg::arith_op, 1'b0);
      `CK("dest write", 1'b1, dest_we)
      `CK("dest data", r, dest_data)
   endtask : nan
   task automatic t_masked;
      nan(SN, RL, SQ, 1'b0);
      `CK("invalid flag", 1'b1, sw_out[0])
      nan(SN, QN, QN, 1'b0);
      nan(SN, SN2, SQ2, 1'b0);
      nan(QN, QN2, QN2, 1'b0);
      nan(QN, RL, QN, 1'b0);
      nan(RL, RL, 80'hFFFF_C000_0000_0000_0000, 1'b1);
      nan(INF, RL, INF, 1'b0);
   endtask : t_masked
   task automatic t_trap;
      mem_cw = 16'h037E;
      op(fpu_nan_wait_pkg::control_word_load_op, 1'b0);
      `CK("cw load", 16'h037E, cw_out)
      op(fpu_nan_wait_pkg::arith_op, 1'b0);
      `CK("arith trap", 2'h2, {trap, done})
      `CK("no write", 1'b0, dest_we)
      op(fpu_nan_wait_pkg::sync_check_op, 1'b0);
      `CK("sync trap", 1'b1, trap)
      for (int i = 0; i < 3; i++) begin
         op(fpu_nan_wait_pkg::op_e'(5'h14 + 5'(i)), 1'b0);
         `CK("legacy", 33'h1_037E_0001, {done, cw_out, sw_out})
      end
      op(fpu_nan_wait_pkg::status_word_store_op, 1'b1);
      `CK("sw store", 17'h1_0001, {mem_we, store_word})
      store_to_gpr = 1'b1;
      op(fpu_nan_wait_pkg::status_word_store_op, 1'b1);
      `CK("sw to gpr", 1'b1, gpr_we)
      op(fpu_nan_wait_pkg::control_word_store_op, 1'b1);
      `CK("cw store", 17'h1_037E, {mem_we, store_word})
      op(fpu_nan_wait_pkg::environment_save_op, 1'b1);
      `CK("env save", 2'h2, {save_env, save_regs})
      op(fpu_nan_wait_pkg::full_state_save_op, 1'b1);
      `CK("state save", 2'h3, {save_env, save_regs})
      op(fpu_nan_wait_pkg::exception_flag_clear_op, 1'b1);
      `CK("cleared", 16'h0000, sw_out)
      src_a = SN;
      inv_req = 1'b1;
      op(fpu_nan_wait_pkg::arith_op, 1'b0);
      `CK("unmasked", 3'h3, {dest_we, sw_out[0], es})
      op(fpu_nan_wait_pkg::unit_initialise_op, 1'b1);
      `CK("init", 48'h037F_0000_FFFF, {cw_out, sw_out, tag_out})
   endtask : t_trap
   task automatic t_stack;
      {mem_cw, mem_sw, mem_tag} = {16'h037F, 32'h0};
      op(fpu_nan_wait_pkg::full_state_restore_op, 1'b0);
      `CK("restore", 17'h1_0000, {load_regs, tag_out})
      op(fpu_nan_wait_pkg::stack_pointer_increment_op, 1'b0);
      `CK("top up", 3'h1, sw_out[13:11])
      op(fpu_nan_wait_pkg::stack_pointer_decrement_op, 1'b0);
      op(fpu_nan_wait_pkg::stack_pointer_decrement_op, 1'b0);
      `CK("top wrap", 3'h7, sw_out[13:11])
      op_reg = 3'h3;
      op(fpu_nan_wait_pkg::register_release_op, 1'b0);
      `CK("release", 16'h0030, tag_out)
      op(fpu_nan_wait_pkg::fp_idle_op, 1'b0);
      `CK("idle", 1'b1, done)
      mem_cw = 16'h027F;
      op(fpu_nan_wait_pkg::environment_load_op, 1'b0);
      `CK("env load", 16'h027F, cw_out)
   endtask : t_stack
   initial begin
      sys_rst = 1'b1;
      op_code = fpu_nan_wait_pkg::op_none;
      {op_valid, op_no_wait, op_reg, store_to_gpr, inv_req, src_a, src_b} = '0;
      src_b_used = 1'b1;
      {mem_cw, mem_sw, mem_tag} = {16'h037F, 32'h0};
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      `CK("reset", 48'h037F_0000_FFFF, {cw_out, sw_out, tag_out})
      t_masked();
      t_trap();
      t_stack();
      give_verdict();
   end
   initial begin
      #20000;
      fail_count++;
      give_verdict();
   end
endmodule : fpu_nan_wait_control_tb
